// ### core/can_accept_filter_irq_mask.sv
// Global identifier acceptance masks and level interrupt gating.
// Assumes a descriptor scanner offering one comparison per cycle and one-cycle
// event pulses from the protocol engine, all synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A global standard mask lets chosen bits of an 11-bit received identifier be ignored.
// - After reset the standard mask requires every standard identifier bit to match.
// - A global extended mask lets any of the 29 extended identifier bits be ignored.
// - After reset the extended mask requires every extended identifier bit to match.
// - Each mask is one copy shared by every receive descriptor.
// - The mask is applied to the bitwise difference of the received and descriptor identifiers.
// - A 16-bit enable word chooses which levels may interrupt the interpreter.
// - Enable bit n for n from 0 to 14 lets the object at level n+1 interrupt.
// - With an enable word of zero no object can interrupt.
// - Enable bit 15 gates interrupts from low-level bus errors.
module can_accept_filter_irq_mask (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [can_accept_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [can_accept_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [can_accept_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Identifier comparison
  input wire logic cmp_valid,
  input wire can_accept_pkg::id_cmp_s cmp_in,
  output logic cmp_done,
  output logic cmp_hit,
  // Events
  input wire logic [can_accept_pkg::OBJ_LEVELS-1:0] level_event,
  input wire logic bus_error,
  // Interrupt to the interpreter
  output logic irq
);

  logic [can_accept_pkg::STD_ID_W-1:0] std_mask_q;
  logic [can_accept_pkg::STD_ID_W-1:0] std_mask_d;
  logic [can_accept_pkg::EXT_ID_W-1:0] ext_mask_q;
  logic [can_accept_pkg::EXT_ID_W-1:0] ext_mask_d;
  logic [can_accept_pkg::LEVELS-1:0] en_q;
  logic [can_accept_pkg::LEVELS-1:0] en_d;
  logic [can_accept_pkg::LEVELS-1:0] pend_q;
  logic [can_accept_pkg::LEVELS-1:0] pend_d;
  logic [can_accept_pkg::DATA_W-1:0] rdata_q;
  logic [can_accept_pkg::DATA_W-1:0] rdata_d;
  logic wait_q;
  logic wait_d;
  logic done_q;
  logic done_d;
  logic hit_q;
  logic hit_d;
  logic irq_q;
  logic irq_d;
  logic req;
  logic bus_wr;
  logic [5:0] idx;
  logic aligned;
  logic [can_accept_pkg::DATA_W-1:0] be_mask;
  logic [can_accept_pkg::DATA_W-1:0] wr_bits;
  logic [can_accept_pkg::LEVELS-1:0] ev_set;
  logic [can_accept_pkg::EXT_ID_W-1:0] diff;

  assign req = avs_read | avs_write;
  assign idx = avs_address[7:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  // Write lands only at the edge where waitrequest is seen low
  assign bus_wr = avs_write & ~wait_q & aligned;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_bits = avs_writedata & be_mask;
  assign ev_set = {bus_error, level_event};

  // Bus handshake: one wait cycle, then a one-cycle answer
  always_comb
  begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if (req && wait_q)
    begin
      wait_d = 1'b0;
      rdata_d = 32'h0000_0000;
      if (avs_read && aligned)
      begin
        unique case (idx)
          can_accept_pkg::IDX_STD_MASK: rdata_d[can_accept_pkg::STD_ID_W-1:0] = std_mask_q;
          can_accept_pkg::IDX_EXT_MASK: rdata_d[can_accept_pkg::EXT_ID_W-1:0] = ext_mask_q;
          can_accept_pkg::IDX_IRQ_EN: rdata_d[can_accept_pkg::LEVELS-1:0] = en_q;
          can_accept_pkg::IDX_IRQ_PEND: rdata_d[can_accept_pkg::LEVELS-1:0] = pend_q;
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Configuration registers with byte-lane writes
  always_comb
  begin
    std_mask_d = std_mask_q;
    ext_mask_d = ext_mask_q;
    en_d = en_q;
    if (bus_wr && idx == can_accept_pkg::IDX_STD_MASK)
    begin
      std_mask_d = (std_mask_q & ~be_mask[10:0]) | wr_bits[10:0];
    end
    if (bus_wr && idx == can_accept_pkg::IDX_EXT_MASK)
    begin
      ext_mask_d = (ext_mask_q & ~be_mask[28:0]) | wr_bits[28:0];
    end
    if (bus_wr && idx == can_accept_pkg::IDX_IRQ_EN)
    begin
      en_d = (en_q & ~be_mask[15:0]) | wr_bits[15:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      std_mask_q <= can_accept_pkg::STD_MASK_RST;
      ext_mask_q <= can_accept_pkg::EXT_MASK_RST;
      en_q <= can_accept_pkg::IRQ_EN_RST;
    end
    else
    begin
      std_mask_q <= std_mask_d;
      ext_mask_q <= ext_mask_d;
      en_q <= en_d;
    end
  end

  // Pending flags: write one to clear; a new event in the same cycle wins
  always_comb
  begin
    pend_d = pend_q;
    if (bus_wr && idx == can_accept_pkg::IDX_IRQ_PEND)
    begin
      pend_d = pend_q & ~wr_bits[15:0];
    end
    pend_d = pend_d | ev_set;
    // Computed from next values so irq lines up with pend_q and en_q
    irq_d = |(pend_d & en_d);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pend_q <= can_accept_pkg::IRQ_PEND_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_d;
      irq_q <= irq_d;
    end
  end

  // Comparison: one shared mask pair for every descriptor, no per-descriptor copy
  always_comb
  begin
    diff = cmp_in.rx_id ^ cmp_in.desc_id;
    done_d = cmp_valid;
    hit_d = 1'b0;
    if (cmp_valid)
    begin
      if (cmp_in.ext)
      begin
        hit_d = ((diff & ~ext_mask_q) == 29'h0000000);
      end
      else
      begin
        hit_d = ((diff[10:0] & ~std_mask_q) == 11'h000);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      done_q <= 1'b0;
      hit_q <= 1'b0;
    end
    else
    begin
      done_q <= done_d;
      hit_q <= hit_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign cmp_done = done_q;
  assign cmp_hit = hit_q;
  assign irq = irq_q;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking

  a_std_mask_reset: assert property (!rst_b |=> std_mask_q == 11'h000)
    else $error("standard mask not zero after reset");

  a_ext_mask_reset: assert property (!rst_b |=> ext_mask_q == 29'h0000000)
    else $error("extended mask not zero after reset");

  a_std_ignored_hit: assert property (disable iff (!rst_b)
    cmp_valid && !cmp_in.ext
    && (((cmp_in.rx_id[10:0] ^ cmp_in.desc_id[10:0]) & ~std_mask_q) == 11'h000)
    |=> cmp_hit && cmp_done)
    else $error("masked standard match missed");

  a_ext_exact_miss: assert property (disable iff (!rst_b)
    cmp_valid && cmp_in.ext
    && (((cmp_in.rx_id ^ cmp_in.desc_id) & ~ext_mask_q) != 29'h0000000)
    |=> !cmp_hit)
    else $error("extended mismatch on cared bit accepted");

  a_ext_full_ignore: assert property (disable iff (!rst_b)
    cmp_valid && cmp_in.ext && (&ext_mask_q) |=> cmp_hit)
    else $error("fully masked extended id rejected");

  a_idle_no_hit: assert property (disable iff (!rst_b)
    !cmp_valid |=> !cmp_done && !cmp_hit)
    else $error("result without comparison");

  a_irq_gate: assert property (disable iff (!rst_b)
    irq == |(pend_q & en_q))
    else $error("irq disagrees with pending and enable");

  a_zero_enable_quiet: assert property (disable iff (!rst_b)
    en_q == 16'h0000 |-> !irq)
    else $error("irq with zero enable word");

  a_level_pending: assert property (disable iff (!rst_b)
    level_event[0] && en_q[0] && !bus_wr |=> pend_q[0] && irq)
    else $error("level one event did not interrupt");

  a_bus_err_irq: assert property (disable iff (!rst_b)
    bus_error && en_q[15] && !bus_wr |=> pend_q[15] ##0 irq)
    else $error("bus error did not interrupt");

  a_enable_write: assert property (disable iff (!rst_b)
    bus_wr && idx == can_accept_pkg::IDX_IRQ_EN && avs_byteenable == 4'hF
    |=> en_q == $past(avs_writedata[15:0]))
    else $error("enable word not written");

  a_wait_answer: assert property (disable iff (!rst_b)
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest answer not one cycle");

  a_std_exact_miss: assert property (disable iff (!rst_b)
    cmp_valid && !cmp_in.ext
    && (((cmp_in.rx_id[10:0] ^ cmp_in.desc_id[10:0]) & ~std_mask_q) != 11'h000)
    |=> !cmp_hit)
    else $error("standard mismatch on cared bit accepted");

  // Unmapped reads must not leak a neighbouring register
  a_rdata_unmapped: assert property (disable iff (!rst_b)
    avs_read && avs_waitrequest && idx > can_accept_pkg::IDX_IRQ_PEND
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_event_beats_clear: assert property (disable iff (!rst_b)
    level_event[1] |=> pend_q[1])
    else $error("level event lost");

  a_pend_sticky: assert property (disable iff (!rst_b)
    !(bus_wr && idx == can_accept_pkg::IDX_IRQ_PEND)
    |=> (pend_q & $past(pend_q)) == $past(pend_q))
    else $error("pending flag dropped without a clear");

  c_std_hit: cover property (disable iff (!rst_b) cmp_valid && !cmp_in.ext ##1 cmp_hit);
  c_ext_hit: cover property (disable iff (!rst_b) cmp_valid && cmp_in.ext ##1 cmp_hit);
  c_irq_rise: cover property (disable iff (!rst_b) !irq ##1 irq);
  c_bus_err_irq: cover property (disable iff (!rst_b) bus_error ##1 irq);
  c_pend_clear: cover property (disable iff (!rst_b)
    bus_wr && idx == can_accept_pkg::IDX_IRQ_PEND ##1 !irq);

endmodule : can_accept_filter_irq_mask

`default_nettype wire

// ### core/can_accept_pkg.sv
// Constants and carrier types for the acceptance masking and level interrupt block.
// Assumes an Avalon-MM byte-addressed slave with 32-bit data.
package can_accept_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STD_ID_W = 11;
  localparam int EXT_ID_W = 29;
  localparam int LEVELS = 16;
  localparam int OBJ_LEVELS = 15;
  localparam int BUS_ERR_BIT = 15;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_STD_MASK = 6'h05;
  localparam logic [5:0] IDX_EXT_MASK = 6'h06;
  localparam logic [5:0] IDX_IRQ_EN = 6'h07;
  localparam logic [5:0] IDX_IRQ_PEND = 6'h08;

  // Reset values: zero mask bits demand an exact match
  localparam logic [STD_ID_W-1:0] STD_MASK_RST = 11'h000;
  localparam logic [EXT_ID_W-1:0] EXT_MASK_RST = 29'h0000000;
  localparam logic [LEVELS-1:0] IRQ_EN_RST = 16'h0000;
  localparam logic [LEVELS-1:0] IRQ_PEND_RST = 16'h0000;

  // One identifier comparison offered by the descriptor scanner
  typedef struct packed {
    logic ext;
    logic [EXT_ID_W-1:0] rx_id;
    logic [EXT_ID_W-1:0] desc_id;
  } id_cmp_s;

endpackage : can_accept_pkg

// ### sim/can_far_model.sv
// Far-side model: protocol engine events and descriptor scanner offers.
// Assumes bench requests arrive by non-blocking assignment after sys_clk rises.
`timescale 1ns/1ps
`default_nettype none
module can_far_model (
  // Clock
  input wire logic sys_clk,
  // Bench requests
  input wire logic [15:0] ev_req,
  input wire logic cmp_req,
  input wire can_accept_pkg::id_cmp_s cmp_req_in,
  // Device side
  output logic [can_accept_pkg::OBJ_LEVELS-1:0] level_event,
  output logic bus_error,
  output logic cmp_valid,
  output can_accept_pkg::id_cmp_s cmp_in
);
  always_ff @(posedge sys_clk)
  begin
    level_event <= ev_req[14:0];
    bus_error <= ev_req[15];
    cmp_valid <= cmp_req;
    // Idle lines toggle so a stale offer is never mistaken for a fresh one
    cmp_in <= cmp_req ? cmp_req_in : ~cmp_in;
  end
endmodule : can_far_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the acceptance masks and level interrupts.
// Assumes the far-side model delays each request by one sys_clk cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, cmp_valid, cmp_done, cmp_hit, bus_error, irq;
  logic cmp_req = 1'b0;
  logic [14:0] level_event;
  logic [15:0] ev_req = 16'h0000;
  can_accept_pkg::id_cmp_s cmp_in;
  can_accept_pkg::id_cmp_s cmp_req_in = '0;
  int failures = 0;
  int check_count = 0;
  int std_m, ext_m, en_m, pend_m, rx, ds, ext, d;

  can_accept_filter_irq_mask can_accept_filter_irq_mask_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_valid(cmp_valid),
    .cmp_in(cmp_in), .cmp_done(cmp_done), .cmp_hit(cmp_hit), .level_event(level_event),
    .bus_error(bus_error), .irq(irq));
  can_far_model can_far_model_inst (.sys_clk(sys_clk), .ev_req(ev_req), .cmp_req(cmp_req),
    .cmp_req_in(cmp_req_in), .level_event(level_event), .bus_error(bus_error),
    .cmp_valid(cmp_valid), .cmp_in(cmp_in));

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Values read right at the edge are the pre-edge ones, i.e. what the slave sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input int v);
    bus(1'b1, a, v);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input int e);
    bus(1'b0, a, 32'h00000000);
    `CHK(q, e[31:0])
  endtask : rdc

  task automatic cmp_chk(input int e, input int r, input int s);
    int m;
    m = e ? (ext_m | 32'hE0000000) : (std_m | 32'hFFFFF800);
    @(posedge sys_clk);
    cmp_req <= 1'b1;
    cmp_req_in <= {e[0], r[28:0], s[28:0]};
    @(posedge sys_clk);
    cmp_req <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(cmp_done, 1'b1)
    `CHK(cmp_hit, ((r ^ s) & ~m) == 0)
  endtask : cmp_chk

  task automatic ev(input int v);
    @(posedge sys_clk);
    ev_req <= v[15:0];
    @(posedge sys_clk);
    ev_req <= 16'h0000;
    pend_m = pend_m | (v & 32'h0000FFFF);
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(irq, (pend_m & en_m) != 0)
  endtask : ev

  initial
  begin
    void'($urandom(32'hC6CEFB98));
    std_m = 0;
    ext_m = 0;
    en_m = 0;
    pend_m = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(8'h14, 0);
    rdc(8'h18, 0);
    rdc(8'h1C, 0);
    rdc(8'h20, 0);
    wr(8'h24, 32'hFFFFFFFF);
    rdc(8'h24, 0);
    wr(8'h15, 32'hFFFFFFFF);
    rdc(8'h14, 0);
    rx = $urandom;
    cmp_chk(0, rx, rx);
    cmp_chk(0, rx, rx ^ 32'h00000400);
    cmp_chk(1, rx, rx ^ 32'h10000000);
    for (int k = 0; k < 3; k++)
    begin
      d = $urandom;
      wr(8'h14, d);
      std_m = d & 32'h000007FF;
      rdc(8'h14, std_m);
      d = $urandom;
      wr(8'h18, d);
      ext_m = d & 32'h1FFFFFFF;
      rdc(8'h18, ext_m);
      for (int j = 0; j < 12; j++)
      begin
        ext = $urandom_range(1);
        rx = $urandom;
        ds = j[0] ? rx ^ ($urandom & (ext ? ext_m : std_m)) : $urandom;
        cmp_chk(ext, rx, ds);
      end
    end
    d = $urandom;
    wr(8'h1C, d);
    en_m = d & 32'h0000FFFF;
    rdc(8'h1C, en_m);
    for (int j = 0; j < 16; j++)
    begin
      ev(1 << j);
      rdc(8'h20, pend_m);
      wr(8'h20, 32'h0000FFFF);
      pend_m = 0;
    end
    wr(8'h1C, 0);
    en_m = 0;
    ev(32'h00007FFF);
    wr(8'h1C, 32'h0000FFFF);
    en_m = 32'h0000FFFF;
    ev(32'h00008000);
    wr(8'h20, 32'h000000FF);
    pend_m = pend_m & 32'hFFFFFF00;
    rdc(8'h20, pend_m);
    @(negedge sys_clk);
    `CHK(irq, (pend_m & en_m) != 0)
    summarize();
  end

  // Whole run needs a few hundred cycles; this leaves a wide margin
  initial
  begin
    #200000;
    failures++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
